/* pkg/bmeh_defines.vh */
// constants for the bus and memory error handler: offsets, fields, resets
`ifndef BMEH_DEFINES_VH
`define BMEH_DEFINES_VH
// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define BMEH_OFS_STATUS 6'h00
`define BMEH_OFS_SIG_DIS 6'h04
`define BMEH_OFS_FATAL 6'h08
`define BMEH_OFS_UNC_ADDR 6'h0C
`define BMEH_OFS_UNC_ID 6'h10
`define BMEH_OFS_UNC_SYN 6'h14
`define BMEH_OFS_COR_ADDR 6'h18
`define BMEH_OFS_COR_ID 6'h1C
`define BMEH_OFS_COR_SYN 6'h20
`define BMEH_OFS_BUS_AD 6'h24
`define BMEH_OFS_BUS_CTRL 6'h28
// ----------------------------------------------------------------------
// error index, shared by status and signaling-disable bits
// ----------------------------------------------------------------------
`define BMEH_E_UNCORR 0
`define BMEH_E_CORR 1
`define BMEH_E_BUFPAR 2
`define BMEH_E_CTRLPAR 3
`define BMEH_E_ADDRPAR 4
`define BMEH_E_DATAPAR 5
`define BMEH_E_BCAST 6
`define BMEH_E_PATH 7
`define BMEH_E_RANGE 8
`define BMEH_NERR 9
// overflow bit positions in the status register
`define BMEH_OVF_UNCORR 16
`define BMEH_OVF_CORR 17
`define BMEH_OVF_BUS 18
// ----------------------------------------------------------------------
// reset values and widths
// ----------------------------------------------------------------------
`define BMEH_SIG_DIS_RST 9'h002
`define BMEH_ADDR_W 32
`define BMEH_ID_W 6
`define BMEH_SYN_W 8
`define BMEH_CTRL_W 16
`define BMEH_DATA_W 32
`endif

/* hw/bmeh_top.v */
// bus and memory error handler: detection, signaling, grouped logging
// Notes on behaviour
// - first error in a group logs and flags; later ones set their own flag and overflow, no log
// - per-error disable suppresses broadcast and fatal, status still kept
// - bus parity errors and range errors share one logging group
// - correctable and uncorrectable memory errors each own a log group
// - observed broadcast and buffer parity error log nothing, they only flag and signal
// - every bus data parity error whose disable bit is clear triggers a broadcast
// - uncorrectable read returns drive address-valid with data-valid
// - uncorrectable read: broadcast, fatal mode, uncorrectable flag
// - uncorrectable log holds address, master id, tag and syndrome
// - correctable read: flag and log address, id, tag, syndrome
// - corrected data is delivered, no scrub write-back is made
// - correctable errors signal nothing unless enabled
// - buffer parity error: broadcast, fatal, flag, no log
// - cache-to-cache uncorrectable data counts as bus data parity error
// - control parity: broadcast, fatal, log bus and control state
// - address parity: broadcast, fatal, flag, log bus and control
// - data parity: broadcast, fatal, log; poison ecc on memory writes
// - observed broadcast: fatal mode and flag, no log, no broadcast
// - observed path error: broadcast, fatal, flag, log bus state
// - out-of-range access: broadcast, fatal, flag, log at address-valid
// - failed processor read of io space is not signaled here
//
// Decided for this implementation: the Avalon-MM register port and the address map.

`include "bmeh_defines.vh"
`timescale 1ns/100ps
`default_nettype none

module bmeh_top (
  input wire i_clock,
  input wire i_arst_n,
  // avalon-mm slave
  input wire [5:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  // memory controller read results
  input wire i_mem_ret_valid,
  input wire [`BMEH_DATA_W-1:0] i_mem_ret_data,
  input wire i_mem_uncorr,
  input wire i_mem_corr,
  input wire i_mem_bufpar,
  input wire i_mem_c2c,
  input wire [`BMEH_ADDR_W-1:0] i_mem_addr,
  input wire [`BMEH_ID_W-1:0] i_mem_mid,
  input wire [`BMEH_ID_W-1:0] i_mem_txn_tag,
  input wire [`BMEH_SYN_W-1:0] i_mem_syndrome,
  // shared bus observation from the bus interface unit
  input wire i_bus_addr_valid,
  input wire i_bus_data_valid,
  input wire [`BMEH_DATA_W-1:0] i_bus_addr_data,
  input wire [`BMEH_CTRL_W-1:0] i_bus_ctrl,
  input wire i_bus_ctrl_par_err,
  input wire i_bus_addr_par_err,
  input wire i_bus_data_par_err,
  input wire i_bus_data_to_mem,
  input wire i_bus_bcast_seen,
  input wire i_bus_range_err,
  // responses
  output reg o_ret_addr_valid,
  output reg o_ret_data_valid,
  output reg [`BMEH_DATA_W-1:0] o_ret_data,
  output reg o_bcast_req,
  output reg o_fatal_mode,
  output reg o_poison_ecc
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  reg [`BMEH_NERR-1:0] stat_reg;
  reg [`BMEH_NERR-1:0] stat_next;
  reg [2:0] ovf_reg;
  reg [2:0] ovf_next;
  // one signaling disable per error kind
  reg [`BMEH_NERR-1:0] sig_dis_reg;
  reg [`BMEH_ADDR_W-1:0] unc_addr_reg;
  reg [`BMEH_ID_W-1:0] unc_mid_reg;
  reg [`BMEH_ID_W-1:0] unc_tag_reg;
  reg [`BMEH_SYN_W-1:0] unc_syn_reg;
  reg [`BMEH_ADDR_W-1:0] cor_addr_reg;
  reg [`BMEH_ID_W-1:0] cor_mid_reg;
  reg [`BMEH_ID_W-1:0] cor_tag_reg;
  reg [`BMEH_SYN_W-1:0] cor_syn_reg;
  reg [`BMEH_DATA_W-1:0] bus_ad_reg;
  reg [`BMEH_CTRL_W-1:0] bus_ctrl_reg;
  reg [31:0] rd_mux;

  // ----------------------------------------------------------------------
  // combinational nets
  // ----------------------------------------------------------------------
  // one bit per error kind, in status order
  wire [`BMEH_NERR-1:0] ev;
  wire [`BMEH_NERR-1:0] sig_en;
  wire mem_uncorr_true;
  wire path_seen;
  wire bus_ev;
  wire unc_busy;
  wire cor_busy;
  wire bus_busy;
  wire wr_fire;
  wire rd_fire;
  wire stat_wr;
  wire sig_wr;
  wire fatal_clr;
  wire any_sig;
  wire any_fatal;

  // ----------------------------------------------------------------------
  // event decode
  // ----------------------------------------------------------------------
  // a cache-to-cache copy with bad data is a bus data fault, not memory
  assign mem_uncorr_true = i_mem_ret_valid & i_mem_uncorr & ~i_mem_c2c;
  // our own path-error drive must not be mistaken for a foreign one
  assign path_seen = i_bus_addr_valid & i_bus_data_valid &
                     ~o_ret_addr_valid;
  assign ev[`BMEH_E_UNCORR] = mem_uncorr_true;
  // a beat marked both ways is uncorrectable only
  assign ev[`BMEH_E_CORR] = i_mem_ret_valid & i_mem_corr &
                            ~i_mem_uncorr;
  assign ev[`BMEH_E_BUFPAR] = i_mem_ret_valid & i_mem_bufpar;

  // bus faults are one-cycle pulses
  assign ev[`BMEH_E_CTRLPAR] = i_bus_ctrl_par_err;
  assign ev[`BMEH_E_ADDRPAR] = i_bus_addr_par_err;
  assign ev[`BMEH_E_DATAPAR] = i_bus_data_par_err |
                               (i_mem_ret_valid & i_mem_uncorr &
                                i_mem_c2c);
  // broadcasts from any agent, ours too
  assign ev[`BMEH_E_BCAST] = i_bus_bcast_seen;
  assign ev[`BMEH_E_PATH] = path_seen;
  // range faults are only judged while the address is on the bus
  assign ev[`BMEH_E_RANGE] = i_bus_range_err & i_bus_addr_valid;

  // failed io-space reads have no input here: the processor's own timeout
  // and the io hub controller handle them, so nothing is signaled

  // ----------------------------------------------------------------------
  // signaling
  // ----------------------------------------------------------------------
  // disables mask broadcast and fatal mode; flags, logs and poison ignore them
  assign sig_en = ev & ~sig_dis_reg;
  // every enabled error except an observed broadcast asks for a broadcast
  assign any_sig = |(sig_en & ~(`BMEH_NERR'd1 << `BMEH_E_BCAST));
  // a seen broadcast is not echoed, or agents would loop
  assign any_fatal = |sig_en;

  // broadcast request pulse, fatal mode level
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_bcast_req <= 1'b0;
      o_fatal_mode <= 1'b0;
    end else begin
      o_bcast_req <= any_sig;
      // a new fault in the clear cycle keeps fatal mode on
      if (any_fatal) begin
        o_fatal_mode <= 1'b1;
      end else if (fatal_clr) begin
        o_fatal_mode <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // read return path
  // ----------------------------------------------------------------------
  // data from the controller is already corrected; there is no write-back
  // port at all, so a scrub can never be issued from here
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ret_addr_valid <= 1'b0;
      o_ret_data_valid <= 1'b0;
      o_ret_data <= 32'h0000_0000;
      o_poison_ecc <= 1'b0;
    end else begin
      // one cycle of delay, no buffering
      o_ret_data_valid <= i_mem_ret_valid;
      o_ret_data <= i_mem_ret_data;
      // bad return beats carry address-valid too, forming a path error
      o_ret_addr_valid <= mem_uncorr_true;
      // a data-path action, so disables do not gate it
      o_poison_ecc <= i_bus_data_par_err & i_bus_data_to_mem;
    end
  end

  // ----------------------------------------------------------------------
  // avalon slave handshake
  // ----------------------------------------------------------------------
  // one wait cycle per access; the read mux is registered on that edge so
  // readdata is stable while waitrequest is low
  // a strobe counts only while waitrequest is low
  assign rd_fire = i_avs_read & ~o_avs_waitrequest;
  assign wr_fire = i_avs_write & ~o_avs_waitrequest;
  // full address decode: misaligned offsets read zero
  assign stat_wr = wr_fire & (i_avs_address == `BMEH_OFS_STATUS);
  assign sig_wr = wr_fire & (i_avs_address == `BMEH_OFS_SIG_DIS);
  assign fatal_clr = wr_fire & (i_avs_address == `BMEH_OFS_FATAL) &
                     i_avs_writedata[0];

  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
    end else begin
      // idle-high waitrequest: one wait cycle per access
      if ((i_avs_read | i_avs_write) & o_avs_waitrequest) begin
        o_avs_waitrequest <= 1'b0;
        o_avs_readdata <= rd_mux;
      end else begin
        o_avs_waitrequest <= 1'b1;
      end
    end
  end

  // read mux; unmapped offsets read zero
  always @* begin
    rd_mux = 32'h0000_0000;
    // reading a log never clears it
    case (i_avs_address)
      `BMEH_OFS_STATUS: begin
        rd_mux[`BMEH_NERR-1:0] = stat_reg;
        rd_mux[`BMEH_OVF_BUS:`BMEH_OVF_UNCORR] = ovf_reg;
      end
      `BMEH_OFS_SIG_DIS: begin
        rd_mux[`BMEH_NERR-1:0] = sig_dis_reg;
      end
      `BMEH_OFS_FATAL: begin
        rd_mux[0] = o_fatal_mode;
      end
      `BMEH_OFS_UNC_ADDR: begin
        rd_mux = unc_addr_reg;
      end
      `BMEH_OFS_UNC_ID: begin
        rd_mux[`BMEH_ID_W-1:0] = unc_tag_reg;
        rd_mux[`BMEH_ID_W+15:16] = unc_mid_reg;
      end
      `BMEH_OFS_UNC_SYN: begin
        rd_mux[`BMEH_SYN_W-1:0] = unc_syn_reg;
      end
      `BMEH_OFS_COR_ADDR: begin
        rd_mux = cor_addr_reg;
      end
      `BMEH_OFS_COR_ID: begin
        rd_mux[`BMEH_ID_W-1:0] = cor_tag_reg;
        rd_mux[`BMEH_ID_W+15:16] = cor_mid_reg;
      end
      `BMEH_OFS_COR_SYN: begin
        rd_mux[`BMEH_SYN_W-1:0] = cor_syn_reg;
      end
      `BMEH_OFS_BUS_AD: begin
        rd_mux = bus_ad_reg;
      end
      `BMEH_OFS_BUS_CTRL: begin
        rd_mux[`BMEH_CTRL_W-1:0] = bus_ctrl_reg;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // signaling disable register; correctable errors start disabled
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sig_dis_reg <= `BMEH_SIG_DIS_RST;
    end else if (sig_wr) begin
      sig_dis_reg <= i_avs_writedata[`BMEH_NERR-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // status and overflow flags
  // ----------------------------------------------------------------------
  // a group is busy while any of its status flags is still set
  // memory groups hold one flag each, the bus group five
  assign unc_busy = stat_reg[`BMEH_E_UNCORR];
  assign cor_busy = stat_reg[`BMEH_E_CORR];
  assign bus_busy = stat_reg[`BMEH_E_CTRLPAR] | stat_reg[`BMEH_E_ADDRPAR] |
                    stat_reg[`BMEH_E_DATAPAR] | stat_reg[`BMEH_E_PATH] |
                    stat_reg[`BMEH_E_RANGE];
  assign bus_ev = ev[`BMEH_E_CTRLPAR] | ev[`BMEH_E_ADDRPAR] |
                  ev[`BMEH_E_DATAPAR] | ev[`BMEH_E_PATH] |
                  ev[`BMEH_E_RANGE];

  // a fault during a clear is never lost

  // write-one-to-clear, with a same-cycle event winning over the clear
  always @* begin
    stat_next = stat_reg;
    ovf_next = ovf_reg;
    if (stat_wr) begin
      stat_next = stat_reg & ~i_avs_writedata[`BMEH_NERR-1:0];
      ovf_next = ovf_reg &
                 ~i_avs_writedata[`BMEH_OVF_BUS:`BMEH_OVF_UNCORR];
    end
    stat_next = stat_next | ev;
    // overflow marks a later fault; the first holds the log
    if (ev[`BMEH_E_UNCORR] & unc_busy) begin
      ovf_next[0] = 1'b1;
    end
    if (ev[`BMEH_E_CORR] & cor_busy) begin
      ovf_next[1] = 1'b1;
    end
    if (bus_ev & bus_busy) begin
      ovf_next[2] = 1'b1;
    end
  end

  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stat_reg <= {`BMEH_NERR{1'b0}};
      ovf_reg <= 3'h0;
    end else begin
      stat_reg <= stat_next;
      ovf_reg <= ovf_next;
    end
  end

  // ----------------------------------------------------------------------
  // logging groups
  // ----------------------------------------------------------------------
  // logs only load while their group is idle, so the first entry survives
  // until software clears the group's flags; buffer parity and observed
  // broadcasts have no log at all
  // separate memory logs: corrected beats never hide
  // the address of an uncorrectable one
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      unc_addr_reg <= 32'h0000_0000;
      unc_mid_reg <= 6'h00;
      unc_tag_reg <= 6'h00;
      unc_syn_reg <= 8'h00;
    end else if (ev[`BMEH_E_UNCORR] & ~unc_busy) begin
      unc_addr_reg <= i_mem_addr;
      unc_mid_reg <= i_mem_mid;
      unc_tag_reg <= i_mem_txn_tag;
      unc_syn_reg <= i_mem_syndrome;
    end
  end

  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cor_addr_reg <= 32'h0000_0000;
      cor_mid_reg <= 6'h00;
      cor_tag_reg <= 6'h00;
      cor_syn_reg <= 8'h00;
    end else if (ev[`BMEH_E_CORR] & ~cor_busy) begin
      cor_addr_reg <= i_mem_addr;
      cor_mid_reg <= i_mem_mid;
      cor_tag_reg <= i_mem_txn_tag;
      cor_syn_reg <= i_mem_syndrome;
    end
  end

  // bus snapshot is taken in the cycle the fault is reported
  // so the control word matches the faulting beat
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bus_ad_reg <= 32'h0000_0000;
      bus_ctrl_reg <= 16'h0000;
    end else if (bus_ev & ~bus_busy) begin
      bus_ad_reg <= i_bus_addr_data;
      bus_ctrl_reg <= i_bus_ctrl;
    end
  end

endmodule // bmeh_top

`default_nettype wire

/* verif/bmeh_chk.sv */
// checker: signaling and return-path timing of the error handler
`timescale 1ns/100ps
`default_nettype none
`include "bmeh_defines.vh"
module bmeh_chk (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic o_avs_waitrequest,
  input wire logic i_mem_ret_valid,
  input wire logic i_mem_uncorr,
  input wire logic i_mem_corr,
  input wire logic i_mem_bufpar,
  input wire logic i_mem_c2c,
  input wire logic i_bus_addr_valid,
  input wire logic i_bus_data_valid,
  input wire logic i_bus_ctrl_par_err,
  input wire logic i_bus_addr_par_err,
  input wire logic i_bus_data_par_err,
  input wire logic i_bus_data_to_mem,
  input wire logic i_bus_bcast_seen,
  input wire logic i_bus_range_err,
  input wire logic o_ret_addr_valid,
  input wire logic o_ret_data_valid,
  input wire logic o_bcast_req,
  input wire logic o_fatal_mode,
  input wire logic o_poison_ecc
);
  // ----------------------------------------------------------------
  // event decode and disable shadow
  // ----------------------------------------------------------------
  logic [8:0] dis_reg;
  logic [8:0] ev;
  logic [8:0] en;
  logic wr_ok;
  logic uc;
  logic clr_f;
  assign wr_ok = i_avs_write && !o_avs_waitrequest;
  assign clr_f = wr_ok && i_avs_address == `BMEH_OFS_FATAL
    && i_avs_writedata[0];
  assign uc = i_mem_ret_valid && i_mem_uncorr;
  // status order; path masked while we drive both valids ourselves
  assign ev = {i_bus_range_err && i_bus_addr_valid,
    i_bus_addr_valid && i_bus_data_valid && !o_ret_addr_valid,
    i_bus_bcast_seen, i_bus_data_par_err || (uc && i_mem_c2c),
    i_bus_addr_par_err, i_bus_ctrl_par_err, i_mem_ret_valid && i_mem_bufpar,
    i_mem_ret_valid && i_mem_corr && !i_mem_uncorr, uc && !i_mem_c2c};
  assign en = ev & ~dis_reg;
  // shadow follows writes only at the accepting edge
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n)
      dis_reg <= `BMEH_SIG_DIS_RST;
    else if (wr_ok && i_avs_address == `BMEH_OFS_SIG_DIS)
      dis_reg <= i_avs_writedata[8:0];
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  property p_path;
    uc && !i_mem_c2c |=> o_ret_addr_valid && o_ret_data_valid;
  endproperty
  a_path: assert property (p_path) else $error("path drive");
  property p_noaddr;
    !(uc && !i_mem_c2c) |=> !o_ret_addr_valid;
  endproperty
  a_noaddr: assert property (p_noaddr) else $error("stray path");
  property p_bcast;
    |(en & 9'h1bf) |=> o_bcast_req;
  endproperty
  a_bcast: assert property (p_bcast) else $error("no bcast");
  property p_quiet;
    !(|(en & 9'h1bf)) |=> !o_bcast_req;
  endproperty
  a_quiet: assert property (p_quiet) else $error("extra bcast");
  property p_fatal;
    |en |=> o_fatal_mode;
  endproperty
  a_fatal: assert property (p_fatal) else $error("no fatal");
  property p_hold;
    o_fatal_mode && !clr_f |=> o_fatal_mode;
  endproperty
  a_hold: assert property (p_hold) else $error("fatal lost");
  property p_calm;
    !o_fatal_mode && !(|en) |=> !o_fatal_mode;
  endproperty
  a_calm: assert property (p_calm) else $error("fatal set");
  property p_poison;
    1'b1 |=> o_poison_ecc == $past(i_bus_data_par_err && i_bus_data_to_mem);
  endproperty
  a_poison: assert property (p_poison) else $error("poison");
endmodule // bmeh_chk
bind bmeh_top bmeh_chk bmeh_chk_i (.i_clock, .i_arst_n, .i_avs_address,
  .i_avs_write, .i_avs_writedata, .o_avs_waitrequest, .i_mem_ret_valid,
  .i_mem_uncorr, .i_mem_corr, .i_mem_bufpar, .i_mem_c2c, .i_bus_addr_valid,
  .i_bus_data_valid, .i_bus_ctrl_par_err, .i_bus_addr_par_err,
  .i_bus_data_par_err, .i_bus_data_to_mem, .i_bus_bcast_seen,
  .i_bus_range_err, .o_ret_addr_valid, .o_ret_data_valid, .o_bcast_req,
  .o_fatal_mode, .o_poison_ecc);
`default_nettype wire

/* verif/bmeh_bus_agent.sv */
// far-side bus agent: observed traffic and error pulses on command
`timescale 1ns/100ps
`default_nettype none
module bmeh_bus_agent (
  input wire logic i_clock,
  input wire logic [2:0] i_cmd, // 1 ctl 2 adr 3 mem 4 bc 5 path 6 rng 7 io
  input wire logic [31:0] i_ad,
  input wire logic [15:0] i_ct,
  output logic o_av,
  output logic o_dv,
  output logic [31:0] o_ad,
  output logic [15:0] o_ct,
  output logic o_cpe,
  output logic o_ape,
  output logic o_dpe,
  output logic o_mem,
  output logic o_bc,
  output logic o_rng
);
  // ----------------------------------------------------------------
  // bus drive
  // ----------------------------------------------------------------
  logic [31:0] idle_pat = 32'h5a5a_a5a5;
  // a released bus toggles so a stale value never looks held
  always @(posedge i_clock) idle_pat <= ~idle_pat;
  // both valids together only when a path error is commanded
  assign o_av = i_cmd == 3'h2 || i_cmd == 3'h5 || i_cmd == 3'h6;
  assign o_dv = i_cmd == 3'h3 || i_cmd == 3'h5 || i_cmd == 3'h7;
  assign o_ad = i_cmd != 3'h0 ? i_ad : idle_pat;
  assign o_ct = i_cmd != 3'h0 ? i_ct : idle_pat[15:0];
  assign o_cpe = i_cmd == 3'h1;
  assign o_ape = i_cmd == 3'h2;
  assign o_dpe = i_cmd == 3'h3 || i_cmd == 3'h7;
  assign o_mem = i_cmd == 3'h3;
  assign o_bc = i_cmd == 3'h4;
  assign o_rng = i_cmd == 3'h6;
endmodule // bmeh_bus_agent
`default_nettype wire

/* verif/bus_memory_error_handler_bench.sv */
// self-checking bench for the bus and memory error handler
`timescale 1ns/100ps
`default_nettype none
`include "bmeh_defines.vh"
module bus_memory_error_handler_bench;
  // ----------------------------------------------------------------
  // design, agent and helpers
  // ----------------------------------------------------------------
  localparam logic [31:0] nil = 32'h0000_0000;
  localparam logic [31:0] one = 32'h0000_0001;
  logic i_clock, i_arst_n, i_avs_read, i_avs_write, o_avs_waitrequest;
  logic [5:0] i_avs_address;
  logic [31:0] i_avs_writedata, o_avs_readdata, i_mem_ret_data, i_mem_addr;
  logic [31:0] o_ret_data, b_ad, i_bus_addr_data, la;
  logic [15:0] b_ct, i_bus_ctrl;
  logic [5:0] i_mem_mid, i_mem_txn_tag;
  logic [7:0] i_mem_syndrome;
  logic i_mem_ret_valid, i_mem_uncorr, i_mem_corr, i_mem_bufpar, i_mem_c2c;
  logic i_bus_addr_valid, i_bus_data_valid, i_bus_ctrl_par_err;
  logic i_bus_addr_par_err, i_bus_data_par_err, i_bus_data_to_mem;
  logic i_bus_bcast_seen, i_bus_range_err, o_ret_addr_valid;
  logic o_ret_data_valid, o_bcast_req, o_fatal_mode, o_poison_ecc;
  logic [2:0] cmd;
  int seed, bad_count, n_compared, cyc;
  bmeh_top bmeh_top_i (.i_clock, .i_arst_n, .i_avs_address, .i_avs_read,
    .i_avs_write, .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest,
    .i_mem_ret_valid, .i_mem_ret_data, .i_mem_uncorr, .i_mem_corr,
    .i_mem_bufpar, .i_mem_c2c, .i_mem_addr, .i_mem_mid, .i_mem_txn_tag,
    .i_mem_syndrome, .i_bus_addr_valid, .i_bus_data_valid, .i_bus_addr_data,
    .i_bus_ctrl, .i_bus_ctrl_par_err, .i_bus_addr_par_err,
    .i_bus_data_par_err, .i_bus_data_to_mem, .i_bus_bcast_seen,
    .i_bus_range_err, .o_ret_addr_valid, .o_ret_data_valid, .o_ret_data,
    .o_bcast_req, .o_fatal_mode, .o_poison_ecc);
  bmeh_bus_agent bmeh_bus_agent_i (.i_clock, .i_cmd(cmd), .i_ad(b_ad),
    .i_ct(b_ct), .o_av(i_bus_addr_valid), .o_dv(i_bus_data_valid),
    .o_ad(i_bus_addr_data), .o_ct(i_bus_ctrl), .o_cpe(i_bus_ctrl_par_err),
    .o_ape(i_bus_addr_par_err), .o_dpe(i_bus_data_par_err),
    .o_mem(i_bus_data_to_mem), .o_bc(i_bus_bcast_seen),
    .o_rng(i_bus_range_err));
  // 100 ns clock
  always #50 i_clock = ~i_clock;
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  function automatic logic [31:0] st(input int b);
    return one << b;
  endfunction
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one access, held until waitrequest is sampled low
  task automatic avs(input logic w, input logic [5:0] a,
      input logic [31:0] d, output logic [31:0] q);
    @(posedge i_clock);
    i_avs_address <= a;
    i_avs_read <= !w;
    i_avs_write <= w;
    i_avs_writedata <= d;
    @(negedge i_clock);
    while (o_avs_waitrequest !== 1'b0) @(negedge i_clock);
    @(posedge i_clock);
    q = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    avs(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e, string nm);
    logic [31:0] q;
    avs(1'b0, a, nil, q);
    check(nm, q, e);
  endtask
  // status is write-one-to-clear; fatal clears through its own bit
  task automatic clr();
    wr(`BMEH_OFS_STATUS, 32'hffff_ffff);
    wr(`BMEH_OFS_FATAL, one);
  endtask
  task automatic beat(input logic u, c, b, x);
    logic [31:0] r;
    r = $random(seed);
    @(posedge i_clock);
    i_mem_ret_valid <= 1'b1;
    {i_mem_uncorr, i_mem_corr, i_mem_bufpar, i_mem_c2c} <= {u, c, b, x};
    i_mem_addr <= $random(seed);
    i_mem_ret_data <= $random(seed);
    {i_mem_mid, i_mem_txn_tag, i_mem_syndrome} <= r[19:0];
    @(posedge i_clock);
    i_mem_ret_valid <= 1'b0;
    @(negedge i_clock);
    check("ret data", o_ret_data, i_mem_ret_data);
    check("ret addr", {31'h0, o_ret_addr_valid}, {31'h0, u & ~x});
  endtask
  task automatic bus(input logic [2:0] c);
    logic [31:0] r;
    r = $random(seed);
    @(posedge i_clock);
    cmd <= c;
    b_ad <= $random(seed);
    b_ct <= r[15:0];
    @(posedge i_clock);
    cmd <= 3'h0;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] ea, ei, q;
    logic [2:0] kc [6];
    int kb [6];
    kc = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
    kb = '{3, 4, 5, 7, 8, 5};
    seed = 81;
    {i_clock, i_arst_n, i_avs_read, i_avs_write, cmd} = '0;
    {i_mem_ret_valid, i_mem_uncorr, i_mem_corr, i_mem_bufpar, i_mem_c2c} = '0;
    {i_avs_address, i_avs_writedata, i_mem_ret_data, i_mem_addr} = '0;
    {i_mem_mid, i_mem_txn_tag, i_mem_syndrome, b_ad, b_ct} = '0;
    repeat (20) @(posedge i_clock);
    i_arst_n <= 1'b1;
    rd(`BMEH_OFS_STATUS, nil, "status");
    rd(`BMEH_OFS_SIG_DIS, 32'h0000_0002, "disable");
    rd(6'h3c, nil, "unmapped");
    beat(1'b1, 1'b0, 1'b0, 1'b0);
    ea = i_mem_addr;
    ei = {10'h000, i_mem_mid, 10'h000, i_mem_txn_tag};
    rd(`BMEH_OFS_STATUS, st(`BMEH_E_UNCORR), "status");
    rd(`BMEH_OFS_UNC_ADDR, ea, "unc addr");
    rd(`BMEH_OFS_UNC_ID, ei, "unc id");
    rd(`BMEH_OFS_UNC_SYN, {24'h00_0000, i_mem_syndrome}, "unc syn");
    rd(`BMEH_OFS_FATAL, one, "fatal");
    beat(1'b1, 1'b0, 1'b0, 1'b0);
    rd(`BMEH_OFS_STATUS, st(0) | st(`BMEH_OVF_UNCORR), "status");
    rd(`BMEH_OFS_UNC_ADDR, ea, "unc addr");
    rd(`BMEH_OFS_UNC_ID, ei, "unc id");
    clr();
    rd(`BMEH_OFS_STATUS, nil, "status");
    beat(1'b0, 1'b1, 1'b0, 1'b0);
    rd(`BMEH_OFS_STATUS, st(`BMEH_E_CORR), "status");
    rd(`BMEH_OFS_COR_ADDR, i_mem_addr, "cor addr");
    rd(`BMEH_OFS_COR_SYN, {24'h00_0000, i_mem_syndrome}, "cor syn");
    rd(`BMEH_OFS_FATAL, nil, "fatal");
    wr(`BMEH_OFS_SIG_DIS, nil);
    beat(1'b0, 1'b1, 1'b0, 1'b0);
    rd(`BMEH_OFS_STATUS, st(1) | st(`BMEH_OVF_CORR), "status");
    rd(`BMEH_OFS_FATAL, one, "fatal");
    clr();
    beat(1'b0, 1'b0, 1'b1, 1'b0);
    rd(`BMEH_OFS_STATUS, st(`BMEH_E_BUFPAR), "status");
    rd(`BMEH_OFS_BUS_AD, nil, "bus ad");
    clr();
    for (int i = 0; i < 6; i++) begin
      bus(kc[i]);
      rd(`BMEH_OFS_STATUS, st(kb[i]), "status");
      rd(`BMEH_OFS_BUS_AD, b_ad, "bus ad");
      rd(`BMEH_OFS_BUS_CTRL, {16'h0000, b_ct}, "bus ctrl");
      rd(`BMEH_OFS_FATAL, one, "fatal");
      clr();
    end
    beat(1'b1, 1'b0, 1'b0, 1'b1);
    rd(`BMEH_OFS_STATUS, st(`BMEH_E_DATAPAR), "status");
    clr();
    bus(3'h2);
    la = b_ad;
    bus(3'h6);
    rd(`BMEH_OFS_STATUS, st(4) | st(8) | st(`BMEH_OVF_BUS), "status");
    rd(`BMEH_OFS_BUS_AD, la, "bus ad");
    clr();
    bus(3'h4);
    rd(`BMEH_OFS_STATUS, st(`BMEH_E_BCAST), "status");
    rd(`BMEH_OFS_BUS_AD, la, "bus ad");
    rd(`BMEH_OFS_FATAL, one, "fatal");
    clr();
    wr(`BMEH_OFS_SIG_DIS, 32'h0000_01ff);
    bus(3'h3);
    rd(`BMEH_OFS_STATUS, st(`BMEH_E_DATAPAR), "status");
    rd(`BMEH_OFS_FATAL, nil, "fatal");
    clr();
    // random masks and events, judged by the checker
    for (int k = 0; k < 16; k++) begin
      q = $random(seed);
      wr(`BMEH_OFS_SIG_DIS, {23'h00_0000, q[8:0]});
      bus(3'h1 + q[11:9] % 3'h7);
      beat(q[12], q[13], q[14], q[15]);
      clr();
    end
    tally_and_finish();
  end
endmodule // bus_memory_error_handler_bench
`default_nettype wire
